// ===== include/sdram_refresh_control_regs.svh
// Register map, reset values and timing counts of the refresh control block
`ifndef SDRAM_REFRESH_CONTROL_REGS_SVH
`define SDRAM_REFRESH_CONTROL_REGS_SVH

`define ADDR_W 12
`define CTRL_OFS 12'h000
`define BLKEN_OFS 12'h004
`define STAT_OFS 12'h008

`define CTRL_W 16
`define CTRL_RESET 16'h0000
`define BLKEN_RESET 2'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define REC_CODE_3 2'h0
`define REC_CODE_6 2'h1
`define REC_CLK_3 4'h3
`define REC_CLK_6 4'h6
`define REC_CLK_9 4'h9
`define REC_ZERO 4'h0
`define REC_ONE 4'h1

`define INTV_W 13
`define INTV_LOW_NIBBLE 4'hF
`define INTV_RESET 13'h000F
`define INTV_ZERO 13'h0000
`define INTV_ONE 13'h0001
`define GAP_ONE 14'h0001

`endif

// ===== include/sdram_refresh_control_pkg.sv
// Types shared by the refresh control block
package sdram_refresh_control_pkg;

  typedef struct packed {
    logic sync;
    logic rsvd;
    logic noAddrMux;
    logic commandOnClockEnable;
    logic selfRefreshRequest;
    logic [1:0] refreshRecoveryTime;
    logic [8:0] refreshIntervalCount;
  } dram_control_reg_t;

  typedef struct packed {
    logic syncMode;
    logic recovering;
    logic inSelfRefresh;
  } status_t;

  typedef enum logic [0:0] {
    AWAKE = 1'b0,
    SLEEP = 1'b1
  } sleep_state_t;

endpackage : sdram_refresh_control_pkg

// ===== hdl/sdram_refresh_control.sv
// SDRAM mode control register, auto-refresh and self-refresh sequencing
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
`include "sdram_refresh_control_regs.svh"
// Operation
// - Bit 15 selects sync memory; zero, the reset value, means async.
// - Sync mode stays set until reset; writes cannot clear it.
// - Bit 13 low multiplexes column addresses; high drives them unmuxed.
// - Bit 12 low: clock enable pin is true enable; self-refresh via bit 11.
// - Bit 12 high: clock enable pin carries command bit; no self-refresh.
// - Bit 11 set with bit 12 low and bit 15 set enters self-refresh for both blocks.
// - Clearing bit 11 after entry sends exit; otherwise nothing happens.
// - Refresh interval counter halts during self-refresh.
// - After refresh, activate waits 3, 6 or 9 clocks per bits 10-9.
// - One recovery setting applies to both memory blocks.
// - Refreshes are spaced (N+1)*16 clocks, N in bits 8-0.
// - Only blocks with their refresh enable set are refreshed.
module sdram_refresh_control (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic cmdBitIn,
  output logic memoryClockEnablePin,
  output logic columnMuxOn,
  output logic asyncMemoryMode,
  output logic refreshCmd,
  output logic [1:0] refreshBlocks,
  output logic sleepEntryCmd,
  output logic sleepRefreshExitCmd,
  output logic activateAllowed
);

  sdram_refresh_control_pkg::dram_control_reg_t ctrl;
  sdram_refresh_control_pkg::dram_control_reg_t next_ctrl;
  sdram_refresh_control_pkg::dram_control_reg_t wrVal;
  sdram_refresh_control_pkg::status_t status;
  sdram_refresh_control_pkg::sleep_state_t sleepState;
  logic [1:0] blockEnable;
  logic awHeld;
  logic wHeld;
  logic [11:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic doWrite;
  logic wrCtrl;
  logic wrBlk;
  logic [3:0] recCnt;
  logic [3:0] recLoad;
  logic [12:0] intervalCnt;
  logic [12:0] intervalLoad;
  logic halted;
  logic tick;
  logic enterReq;
  logic exitReq;

  // Write channel capture, address and data in either order
  assign awready = !awHeld;
  assign wready = !wHeld;
  assign arready = !rvalid;
  assign doWrite = awHeld && wHeld && !bvalid;
  assign wrCtrl = doWrite && (awAddrQ == `CTRL_OFS);
  assign wrBlk = doWrite && (awAddrQ == `BLKEN_OFS);
  assign wrVal = wDataQ[`CTRL_W-1:0];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      awAddrQ <= 12'h000;
    end else if (awvalid && awready) begin
      awHeld <= 1'b1;
      awAddrQ <= awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wHeld <= 1'b0;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
    end else if (wvalid && wready) begin
      wHeld <= 1'b1;
      wDataQ <= wdata;
      wStrbQ <= wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= (wrCtrl || wrBlk) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control register update by byte lane
  always_comb begin
    next_ctrl = ctrl;
    if (wrCtrl && wStrbQ[0]) begin
      next_ctrl.refreshIntervalCount[7:0] = wrVal.refreshIntervalCount[7:0];
    end
    if (wrCtrl && wStrbQ[1]) begin
      next_ctrl.refreshIntervalCount[8] = wrVal.refreshIntervalCount[8];
      next_ctrl.refreshRecoveryTime = wrVal.refreshRecoveryTime;
      next_ctrl.selfRefreshRequest = wrVal.selfRefreshRequest;
      next_ctrl.commandOnClockEnable = wrVal.commandOnClockEnable;
      next_ctrl.noAddrMux = wrVal.noAddrMux;
      next_ctrl.sync = ctrl.sync | wrVal.sync;
    end
    next_ctrl.rsvd = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl <= `CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      blockEnable <= `BLKEN_RESET;
    end else if (wrBlk && wStrbQ[0]) begin
      blockEnable <= wDataQ[1:0];
    end
  end

  // Read channel
  assign status.syncMode = ctrl.sync;
  assign status.recovering = !activateAllowed;
  assign status.inSelfRefresh = (sleepState ==
    sdram_refresh_control_pkg::SLEEP);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      case (araddr)
        `CTRL_OFS: rdata <= {16'h0000, ctrl};
        `BLKEN_OFS: rdata <= {30'h0000_0000, blockEnable};
        `STAT_OFS: rdata <= {29'h0000_0000, status};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Mode pins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      asyncMemoryMode <= 1'b1;
      columnMuxOn <= 1'b1;
      memoryClockEnablePin <= 1'b1;
    end else begin
      asyncMemoryMode <= !ctrl.sync;
      columnMuxOn <= !ctrl.noAddrMux;
      if (ctrl.commandOnClockEnable) begin
        memoryClockEnablePin <= cmdBitIn;
      end else begin
        memoryClockEnablePin <= !(enterReq || status.inSelfRefresh) ||
          exitReq;
      end
    end
  end

  // Self-refresh sequencing
  assign halted = status.inSelfRefresh;
  assign tick = (intervalCnt == `INTV_ZERO) && !halted;
  assign enterReq = (sleepState == sdram_refresh_control_pkg::AWAKE) &&
    ctrl.selfRefreshRequest && !ctrl.commandOnClockEnable && ctrl.sync &&
    activateAllowed && !tick;
  assign exitReq = (sleepState == sdram_refresh_control_pkg::SLEEP) &&
    !ctrl.selfRefreshRequest;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sleepState <= sdram_refresh_control_pkg::AWAKE;
      sleepEntryCmd <= 1'b0;
      sleepRefreshExitCmd <= 1'b0;
    end else begin
      sleepEntryCmd <= enterReq;
      sleepRefreshExitCmd <= exitReq;
      case (sleepState)
        sdram_refresh_control_pkg::AWAKE: begin
          if (enterReq) begin
            sleepState <= sdram_refresh_control_pkg::SLEEP;
          end
        end
        sdram_refresh_control_pkg::SLEEP: begin
          if (exitReq) begin
            sleepState <= sdram_refresh_control_pkg::AWAKE;
          end
        end
        default: sleepState <= sdram_refresh_control_pkg::AWAKE;
      endcase
    end
  end

  // Refresh interval counter
  assign intervalLoad = {ctrl.refreshIntervalCount, `INTV_LOW_NIBBLE};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      intervalCnt <= `INTV_RESET;
    end else if (halted) begin
      intervalCnt <= intervalCnt;
    end else if (tick) begin
      intervalCnt <= intervalLoad;
    end else begin
      intervalCnt <= intervalCnt - `INTV_ONE;
    end
  end

  // Auto-refresh command and activate hold-off
  always_comb begin
    case (ctrl.refreshRecoveryTime)
      `REC_CODE_3: recLoad = `REC_CLK_3;
      `REC_CODE_6: recLoad = `REC_CLK_6;
      default: recLoad = `REC_CLK_9;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      refreshCmd <= 1'b0;
      refreshBlocks <= 2'h0;
      recCnt <= `REC_ZERO;
    end else if (tick && (|blockEnable)) begin
      refreshCmd <= 1'b1;
      refreshBlocks <= blockEnable;
      recCnt <= recLoad;
    end else begin
      refreshCmd <= 1'b0;
      refreshBlocks <= 2'h0;
      if (recCnt != `REC_ZERO) begin
        recCnt <= recCnt - `REC_ONE;
      end
    end
  end

  assign activateAllowed = (recCnt == `REC_ZERO);

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic [13:0] gapCnt;
  logic [13:0] gapLen;
  logic gapValid;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gapCnt <= `GAP_ONE;
      gapLen <= `GAP_ONE;
      gapValid <= 1'b0;
    end else if (tick) begin
      gapCnt <= `GAP_ONE;
      gapLen <= {1'b0, intervalLoad} + `GAP_ONE;
      gapValid <= 1'b1;
    end else if (!halted) begin
      gapCnt <= gapCnt + `GAP_ONE;
    end
  end

  sync_sticky_a: assert property (ctrl.sync |=> ctrl.sync)
    else $error("sync mode dropped without reset");
  async_pin_a: assert property (##1 asyncMemoryMode == !$past(ctrl.sync))
    else $error("async mode pin wrong");
  col_mux_a: assert property (##1 columnMuxOn == !$past(ctrl.noAddrMux))
    else $error("column mux pin wrong");
  cke_cmd_a: assert property (ctrl.commandOnClockEnable |=>
    memoryClockEnablePin == $past(cmdBitIn))
    else $error("clock enable pin not carrying command");
  sleep_cke_a: assert property (!ctrl.commandOnClockEnable &&
    status.inSelfRefresh && !exitReq |=> !memoryClockEnablePin)
    else $error("clock enable high during self-refresh");
  entry_gate_a: assert property (sleepEntryCmd |->
    $past(ctrl.selfRefreshRequest) && !$past(ctrl.commandOnClockEnable))
    else $error("self-refresh entry without request");
  exit_a: assert property (status.inSelfRefresh &&
    !ctrl.selfRefreshRequest |=> sleepRefreshExitCmd &&
    !status.inSelfRefresh)
    else $error("self-refresh exit missing");
  halt_a: assert property (status.inSelfRefresh |-> !refreshCmd ##1
    $stable(intervalCnt))
    else $error("refresh counting during self-refresh");
  rec_three_a: assert property (refreshCmd &&
    ctrl.refreshRecoveryTime == `REC_CODE_3 && $stable(ctrl) |->
    !activateAllowed [*3] ##1 activateAllowed)
    else $error("3 clock recovery wrong");
  rec_six_a: assert property (refreshCmd &&
    ctrl.refreshRecoveryTime == `REC_CODE_6 && $stable(ctrl) |->
    !activateAllowed [*6] ##1 activateAllowed)
    else $error("6 clock recovery wrong");
  gap_len_a: assert property (tick && gapValid |-> gapCnt == gapLen)
    else $error("refresh spacing wrong");
  blk_mask_a: assert property (refreshCmd |-> refreshBlocks ==
    $past(blockEnable) && refreshBlocks != 2'h0)
    else $error("refresh sent to disabled block");

  refresh_seen_c: cover property (refreshCmd);
  sleep_cycle_c: cover property (sleepEntryCmd ##[1:200]
    sleepRefreshExitCmd);
  write_done_c: cover property (bvalid && bready);
  cmd_cke_c: cover property (ctrl.commandOnClockEnable &&
    ctrl.selfRefreshRequest);

endmodule : sdram_refresh_control

// ===== sim/sdram_model.sv
// Behavioural model of the two external memory blocks
`timescale 1ns/1ns
module sdram_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic refreshCmd,
  input wire logic sleepEntryCmd,
  input wire logic sleepRefreshExitCmd,
  input wire logic memoryClockEnablePin,
  output logic cmdBit,
  output logic asleep,
  output logic badRefresh
);
  // Outside command logic: a bit that changes every cycle
  always_ff @(posedge clk) begin
    if (!rst_b) cmdBit <= 1'h0;
    else cmdBit <= !cmdBit;
  end
  // Both blocks sleep from an entry command with clock enable low until the exit command
  always_ff @(posedge clk) begin
    if (!rst_b) asleep <= 1'h0;
    else if (sleepEntryCmd && !memoryClockEnablePin) asleep <= 1'h1;
    else if (sleepRefreshExitCmd) asleep <= 1'h0;
  end
  // A refresh that reaches a sleeping block is a fault
  always_ff @(posedge clk) begin
    if (!rst_b) badRefresh <= 1'h0;
    else if (refreshCmd && asleep) badRefresh <= 1'h1;
  end
endmodule : sdram_model

// ===== sim/sdram_refresh_control_tb.sv
// Self-checking bench for the refresh control block
`timescale 1ns/1ns
`include "sdram_refresh_control_regs.svh"
module sdram_refresh_control_tb;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, cmdBitIn, cke, colMux;
  logic asyncMode, refreshCmd, sleepEntry, sleepExit, actOk, asleep, badRef;
  logic [1:0] bresp, rresp, refreshBlocks, r, en;
  logic [31:0] rdata, d;
  logic p;
  int errorCnt = 0;
  int compares = 0;
  int n, k;

  always #5 clk = ~clk;

  sdram_refresh_control i_dut (.clk(clk), .rst_b(rst_b), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cmdBitIn(cmdBitIn), .memoryClockEnablePin(cke), .columnMuxOn(colMux),
    .asyncMemoryMode(asyncMode), .refreshCmd(refreshCmd),
    .refreshBlocks(refreshBlocks), .sleepEntryCmd(sleepEntry),
    .sleepRefreshExitCmd(sleepExit), .activateAllowed(actOk));

  sdram_model i_mem (.clk(clk), .rst_b(rst_b), .refreshCmd(refreshCmd),
    .sleepEntryCmd(sleepEntry), .sleepRefreshExitCmd(sleepExit),
    .memoryClockEnablePin(cke), .cmdBit(cmdBitIn), .asleep(asleep),
    .badRefresh(badRef));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [15:0] v,
                    output logic [1:0] rs);
    int t;
    t = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      t++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid && t < 100);
    rs = bresp;
    bready <= 1'h0;
    if (t >= 100) chk(32'h0000_0001, 32'h0000_0000);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    int t;
    t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      t++;
      if (arready) arvalid <= 1'h0;
    end while (!rvalid && t < 100);
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
    if (t >= 100) chk(32'h0000_0001, 32'h0000_0000);
  endtask : rd

  task automatic waitSig(input int sel);
    logic [2:0] s;
    int t;
    t = 0;
    do begin
      @(posedge clk);
      t++;
      s = {sleepExit, sleepEntry, refreshCmd};
    end while (!s[sel] && t < 3000);
    if (t >= 3000) chk(32'h0000_0001, 32'h0000_0000);
  endtask : waitSig

  task automatic cnt(input int cyc, input logic [2:0] m, output int c);
    c = 0;
    repeat (cyc) begin
      @(posedge clk);
      c += int'(|({sleepExit, sleepEntry, refreshCmd} & m));
    end
  endtask : cnt

  task automatic modeTest;
    wr(`CTRL_OFS, 16'hA000, r);
    chk(r, `RESP_OKAY);
    rd(`CTRL_OFS, d, r);
    chk(r, `RESP_OKAY);
    chk(d, 32'h0000_A000);
    chk({30'h0000_0000, asyncMode, colMux}, 32'h0000_0000);
    wr(`CTRL_OFS, 16'h0000, r);
    rd(`CTRL_OFS, d, r);
    chk(d, 32'h0000_8000);
    chk({30'h0000_0000, asyncMode, colMux}, 32'h0000_0001);
  endtask : modeTest

  task automatic refreshTest;
    for (int i = 0; i < 3; i++) begin
      en = 2'(3 - i);
      wr(`BLKEN_OFS, {14'h0000, en}, r);
      wr(`CTRL_OFS, {5'h10, 2'(i), 9'(i)}, r);
      waitSig(0);
      waitSig(0);
      chk(refreshBlocks, en);
      k = int'(!actOk);
      n = 0;
      do begin
        @(posedge clk);
        n++;
        if (!actOk && !refreshCmd) k++;
      end while (!refreshCmd && n < 2000);
      chk(n, (i + 1) * 16);
      chk(k, (i + 1) * 3);
    end
  endtask : refreshTest

  task automatic sleepTest;
    wr(`BLKEN_OFS, 16'h0003, r);
    wr(`CTRL_OFS, 16'h8800, r);
    waitSig(1);
    chk(cke, 1'h0);
    cnt(100, 3'h7, n);
    chk(n, 0);
    chk(asleep, 1'h1);
    rd(`STAT_OFS, d, r);
    chk(d, 32'h0000_0005);
    wr(`CTRL_OFS, 16'h8000, r);
    waitSig(2);
    chk(cke, 1'h1);
    cnt(50, 3'h6, n);
    chk(n, 0);
    waitSig(0);
  endtask : sleepTest

  task automatic cocTest;
    wr(`CTRL_OFS, 16'h9000, r);
    @(posedge clk);
    p = cmdBitIn;
    repeat (8) begin
      @(posedge clk);
      chk(cke, p);
      p = cmdBitIn;
    end
    wr(`CTRL_OFS, 16'h9800, r);
    cnt(50, 3'h2, n);
    chk(n, 0);
    wr(`CTRL_OFS, 16'h8000, r);
    @(posedge clk);
    chk(cke, 1'h1);
  endtask : cocTest

  task automatic mapTest;
    rd(12'h00C, d, r);
    chk(r, `RESP_SLVERR);
    chk(d, 32'h0000_0000);
    wr(12'h00C, 16'hFFFF, r);
    chk(r, `RESP_SLVERR);
    // Low byte lane only: upper control bits must not change
    wstrb <= 4'h1;
    wr(`CTRL_OFS, 16'h0855, r);
    wstrb <= 4'hF;
    rd(`CTRL_OFS, d, r);
    chk(d, 32'h0000_8055);
  endtask : mapTest

  task automatic finalReport;
    $display("Compares %0d, errors %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finalReport

  initial begin
    #200000;
    errorCnt++;
    finalReport();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    rd(`CTRL_OFS, d, r);
    chk(d, 32'h0000_0000);
    chk({30'h0000_0000, asyncMode, colMux}, 32'h0000_0003);
    modeTest();
    refreshTest();
    sleepTest();
    cocTest();
    mapTest();
    chk(badRef, 1'h0);
    finalReport();
  end
endmodule : sdram_refresh_control_tb
